// >>> shared/ics_pkg.sv
// Contract
// (RQ1) Force-on keeps outputs alive before calibration
// (RQ2) Bypass routes selected input past PLL
// (RQ3) Host bypasses only when frozen or uncalibrated
// (RQ4) Host never bypasses with CMOS outputs
// (RQ5) Second priority field names second input
// (RQ6) First priority field names first input
// (RQ7) New bandwidth code applies after calibration; the code latches it when calibration starts
// (RQ8) Manual register choice picks input, pin off
// (RQ9) Pin control overrides register manual choice
// (RQ10) Squelch bit disables outputs during calibration
// (RQ11) Method field picks manual, nonrevertive, revertive
// (RQ12) Host writes undefined bits with reset values
// (RQ13) Reserved bits ignore writes, read reset value
package ics_pkg;
   localparam logic [7:0] ICS_OFS_SQUELCH_BYPASS = 8'h00;
   localparam logic [7:0] ICS_OFS_PRIORITY = 8'h01;
   localparam logic [7:0] ICS_OFS_BANDWIDTH = 8'h02;
   localparam logic [7:0] ICS_OFS_SELECT_SQUELCH = 8'h03;
   localparam logic [7:0] ICS_OFS_METHOD = 8'h04;
   localparam logic [7:0] ICS_RST_SQUELCH_BYPASS = 8'h14;
   localparam logic [7:0] ICS_RST_PRIORITY = 8'he4;
   localparam logic [7:0] ICS_RST_BANDWIDTH = 8'h42;
   localparam logic [7:0] ICS_RST_SELECT_SQUELCH = 8'h05;
   localparam logic [7:0] ICS_RST_METHOD = 8'h12;
   // Writable bit masks per register
   localparam logic [7:0] ICS_WM_SQUELCH_BYPASS = 8'h22;
   localparam logic [7:0] ICS_WM_PRIORITY = 8'h0f;
   localparam logic [7:0] ICS_WM_BANDWIDTH = 8'hf0;
   localparam logic [7:0] ICS_WM_SELECT_SQUELCH = 8'hd0;
   localparam logic [7:0] ICS_WM_METHOD = 8'hc0;
   localparam int ICS_POS_FORCE_ON = 5;
   localparam int ICS_POS_BYPASS = 1;
   localparam int ICS_POS_PRIO2 = 2;
   localparam int ICS_POS_PRIO1 = 0;
   localparam int ICS_POS_BW = 4;
   localparam int ICS_POS_MANUAL = 6;
   localparam int ICS_POS_SQ_CAL = 4;
   localparam int ICS_POS_METHOD = 6;
   localparam logic [1:0] ICS_IN_ONE = 2'h0;
   localparam logic [1:0] ICS_IN_TWO = 2'h1;
   localparam logic [1:0] ICS_SEL_MANUAL = 2'h0;
   localparam logic [1:0] ICS_SEL_NONREV = 2'h1;
   localparam logic [1:0] ICS_SEL_REVERT = 2'h2;
   typedef enum logic [1:0] {ICS_ST_ONE, ICS_ST_TWO} ics_state_t;
endpackage

// >>> shared/ics_sel_if.sv
`timescale 1ns/1ps
interface ics_sel_if;
   logic [1:0] method;
   logic [1:0] prio1;
   logic [1:0] prio2;
   logic [1:0] manual;
   logic pin_en;
   logic pin_sel;
   logic in1_bad;
   logic in2_bad;
   logic sel_two;
   modport ctrl (output method, prio1, prio2, manual, pin_en, pin_sel,
      in1_bad, in2_bad, input sel_two);
   modport sel (input method, prio1, prio2, manual, pin_en, pin_sel,
      in1_bad, in2_bad, output sel_two);
endinterface

// >>> core/ics_input_select.sv
`timescale 1ns/1ps
module ics_input_select
   import ics_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   ics_sel_if.sel s
);
   ics_state_t state_q, state_d;

   function automatic logic code_is_two(input logic [1:0] code);
      // Reserved codes fall back to input one
      return code == ICS_IN_TWO;
   endfunction

   always_comb begin
      logic first_two;
      logic first_bad;
      logic cur_bad;
      first_two = code_is_two(s.prio1); // see (RQ6)
      if (s.prio1 == s.prio2) begin
         first_two = code_is_two(s.prio1);
      end
      first_bad = first_two ? s.in2_bad : s.in1_bad;
      cur_bad = (state_q == ICS_ST_TWO) ? s.in2_bad : s.in1_bad;
      state_d = state_q;
      case (s.method) // see (RQ11)
         ICS_SEL_MANUAL: begin
            if (s.pin_en) begin
               state_d = s.pin_sel ? ICS_ST_TWO : ICS_ST_ONE; // see (RQ9)
            end else begin
               state_d = code_is_two(s.manual) ? ICS_ST_TWO
                  : ICS_ST_ONE; // see (RQ8)
            end
         end
         ICS_SEL_NONREV: begin
            // Stay on the current input until it fails
            if (cur_bad) begin
               state_d = code_is_two(s.prio2) ? ICS_ST_TWO
                  : ICS_ST_ONE; // see (RQ5)
               if (state_d == state_q) begin
                  state_d = (state_q == ICS_ST_TWO) ? ICS_ST_ONE
                     : ICS_ST_TWO;
               end
            end
         end
         ICS_SEL_REVERT: begin
            // Return to first priority as soon as it is healthy
            if (!first_bad) begin
               state_d = first_two ? ICS_ST_TWO : ICS_ST_ONE;
            end else begin
               state_d = code_is_two(s.prio2) ? ICS_ST_TWO
                  : ICS_ST_ONE; // see (RQ5)
            end
         end
         default: state_d = state_q;
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state_q <= ICS_ST_ONE;
      end else begin
         state_q <= state_d;
      end
   end

   assign s.sel_two = (state_q == ICS_ST_TWO);
endmodule

// >>> core/ics_clock_ctrl.sv
`timescale 1ns/1ps
module ics_clock_ctrl
   import ics_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   output logic [7:0] reg_rdata,
   input wire logic input_select_pin,
   input wire logic pin_select_enable,
   input wire logic input_one_bad,
   input wire logic input_two_bad,
   input wire logic cal_start,
   input wire logic cal_done,
   input wire logic cal_ok,
   output logic select_input_two,
   output logic pll_bypass,
   output logic outputs_enable,
   output logic [3:0] active_bandwidth_code,
   output logic cal_running,
   output logic cal_complete
);
   logic [7:0] r0_q, r0_d, r1_q, r1_d, r2_q, r2_d, r3_q, r3_d;
   logic [7:0] r4_q, r4_d;
   logic [3:0] bw_q, bw_d;
   logic cal_run_q, cal_run_d, cal_ok_q, cal_ok_d;
   logic bypass_q, bypass_d, oen_q, oen_d;
   logic pin_m_q, pin_s_q, bad1_m_q, bad1_s_q, bad2_m_q, bad2_s_q;
   logic start_m_q, start_s_q, done_m_q, done_s_q, ok_m_q, ok_s_q;
   logic pen_m_q, pen_s_q;
   ics_sel_if sif ();

   // Keep read-only bits at reset value
   function automatic logic [7:0] merge(input logic [7:0] old,
      input logic [7:0] wd, input logic [7:0] wm);
      return (old & ~wm) | (wd & wm); // see (RQ13)
   endfunction

   // Pins and analog status are asynchronous
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pin_m_q <= 1'b0;
         pin_s_q <= 1'b0;
         bad1_m_q <= 1'b0;
         bad1_s_q <= 1'b0;
         bad2_m_q <= 1'b0;
         bad2_s_q <= 1'b0;
         start_m_q <= 1'b0;
         start_s_q <= 1'b0;
         done_m_q <= 1'b0;
         done_s_q <= 1'b0;
         ok_m_q <= 1'b0;
         ok_s_q <= 1'b0;
         pen_m_q <= 1'b0;
         pen_s_q <= 1'b0;
      end else begin
         pin_m_q <= input_select_pin;
         pin_s_q <= pin_m_q;
         bad1_m_q <= input_one_bad;
         bad1_s_q <= bad1_m_q;
         bad2_m_q <= input_two_bad;
         bad2_s_q <= bad2_m_q;
         start_m_q <= cal_start;
         start_s_q <= start_m_q;
         done_m_q <= cal_done;
         done_s_q <= done_m_q;
         ok_m_q <= cal_ok;
         ok_s_q <= ok_m_q;
         // Strap is a pin too; a change only lands two edges late
         pen_m_q <= pin_select_enable;
         pen_s_q <= pen_m_q;
      end
   end

   always_comb begin
      r0_d = r0_q;
      r1_d = r1_q;
      r2_d = r2_q;
      r3_d = r3_q;
      r4_d = r4_q;
      if (reg_wr) begin
         case (reg_addr)
            ICS_OFS_SQUELCH_BYPASS:
               r0_d = merge(r0_q, reg_wdata, ICS_WM_SQUELCH_BYPASS);
            ICS_OFS_PRIORITY:
               r1_d = merge(r1_q, reg_wdata, ICS_WM_PRIORITY);
            ICS_OFS_BANDWIDTH:
               r2_d = merge(r2_q, reg_wdata, ICS_WM_BANDWIDTH);
            ICS_OFS_SELECT_SQUELCH:
               r3_d = merge(r3_q, reg_wdata, ICS_WM_SELECT_SQUELCH);
            ICS_OFS_METHOD:
               r4_d = merge(r4_q, reg_wdata, ICS_WM_METHOD);
            default: r0_d = r0_q;
         endcase
      end
   end

   always_comb begin
      case (reg_addr)
         ICS_OFS_SQUELCH_BYPASS: reg_rdata = r0_q;
         ICS_OFS_PRIORITY: reg_rdata = r1_q;
         ICS_OFS_BANDWIDTH: reg_rdata = r2_q;
         ICS_OFS_SELECT_SQUELCH: reg_rdata = r3_q;
         ICS_OFS_METHOD: reg_rdata = r4_q;
         default: reg_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         r0_q <= ICS_RST_SQUELCH_BYPASS;
         r1_q <= ICS_RST_PRIORITY;
         r2_q <= ICS_RST_BANDWIDTH;
         r3_q <= ICS_RST_SELECT_SQUELCH;
         r4_q <= ICS_RST_METHOD;
      end else begin
         r0_q <= r0_d;
         r1_q <= r1_d;
         r2_q <= r2_d;
         r3_q <= r3_d;
         r4_q <= r4_d;
      end
   end

   assign sif.method = r4_q[ICS_POS_METHOD +: 2];
   assign sif.prio1 = r1_q[ICS_POS_PRIO1 +: 2];
   assign sif.prio2 = r1_q[ICS_POS_PRIO2 +: 2];
   assign sif.manual = r3_q[ICS_POS_MANUAL +: 2];
   assign sif.pin_en = pen_s_q;
   assign sif.pin_sel = pin_s_q;
   assign sif.in1_bad = bad1_s_q;
   assign sif.in2_bad = bad2_s_q;

   ics_input_select u_sel (
      .ref_clk(ref_clk),
      .reset(reset),
      .s(sif.sel)
   );

   // Calibration tracking and output gating
   always_comb begin
      logic squelch;
      squelch = 1'b0;
      cal_run_d = cal_run_q;
      cal_ok_d = cal_ok_q;
      bw_d = bw_q;
      if (start_s_q) begin
         cal_run_d = 1'b1;
         // Latch bandwidth at calibration start only
         bw_d = r2_q[ICS_POS_BW +: 4]; // see (RQ7)
      end else if (cal_run_q && done_s_q) begin
         cal_run_d = 1'b0;
         cal_ok_d = ok_s_q;
      end
      if (r3_q[ICS_POS_SQ_CAL] && cal_run_q) begin
         squelch = 1'b1; // see (RQ10)
      end
      if (!cal_ok_q) begin
         squelch = 1'b1; // see (RQ1)
      end
      if (r0_q[ICS_POS_FORCE_ON]) begin
         squelch = 1'b0; // see (RQ1)
      end
      oen_d = !squelch;
      bypass_d = r0_q[ICS_POS_BYPASS]; // see (RQ2)
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cal_run_q <= 1'b0;
         cal_ok_q <= 1'b0;
         bw_q <= ICS_RST_BANDWIDTH[ICS_POS_BW +: 4];
         oen_q <= 1'b0;
         bypass_q <= 1'b0;
      end else begin
         cal_run_q <= cal_run_d;
         cal_ok_q <= cal_ok_d;
         bw_q <= bw_d;
         oen_q <= oen_d;
         bypass_q <= bypass_d;
      end
   end

   // Bypass path is only valid per host usage; see (RQ3) (RQ4)
   assign select_input_two = sif.sel_two;
   assign pll_bypass = bypass_q;
   assign outputs_enable = oen_q;
   assign active_bandwidth_code = bw_q;
   assign cal_running = cal_run_q;
   assign cal_complete = cal_ok_q;
endmodule

// >>> tb/ics_clock_ctrl_monitor.sv
`timescale 1ns/1ps
module ics_clock_ctrl_monitor
   import ics_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [7:0] reg_rdata,
   input wire logic pll_bypass,
   input wire logic outputs_enable,
   input wire logic [3:0] active_bandwidth_code,
   input wire logic cal_running,
   input wire logic cal_complete
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);
   bypass_copy_a: assert property (
      reg_wr && reg_addr == 8'h00 |-> ##2
      pll_bypass == $past(reg_wdata[1], 2)) else $error("bypass copy");
   bypass_cause_a: assert property (
      $changed(pll_bypass) |-> $past(reg_wr && reg_addr == 8'h00, 2))
      else $error("bypass changed unprompted");
   force_on_a: assert property (
      reg_wr && reg_addr == 8'h00 && reg_wdata[5] |-> ##[1:3]
      outputs_enable) else $error("force-on ignored");
   bw_hold_a: assert property (
      $changed(active_bandwidth_code) |-> $rose(cal_running))
      else $error("bandwidth changed outside calibration");
   cal_end_a: assert property (
      $rose(cal_complete) |-> $fell(cal_running))
      else $error("complete without calibration end");
   unmapped_zero_a: assert property (
      reg_addr > 8'h04 |-> reg_rdata == 8'h00) else $error("unmapped read");
   rsvd_ctrl_a: assert property (
      reg_addr == 8'h00 |-> (reg_rdata & 8'hdd) == 8'h14)
      else $error("reserved bits of control register");
   rsvd_bw_a: assert property (
      reg_addr == 8'h02 |-> reg_rdata[3:0] == 4'h2)
      else $error("reserved bits of bandwidth register");
endmodule
bind ics_clock_ctrl ics_clock_ctrl_monitor mon (.ref_clk, .reset,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rdata, .pll_bypass,
   .outputs_enable, .active_bandwidth_code, .cal_running, .cal_complete);

// >>> tb/ics_cal_model.sv
`timescale 1ns/1ps
module ics_cal_model (
   input wire logic ref_clk,
   output logic cal_start,
   output logic cal_done,
   output logic cal_ok
);
   initial begin
      cal_start = 1'b0;
      cal_done = 1'b0;
      cal_ok = 1'b0;
   end
   // Held past the two-edge sync path
   task automatic begin_cal();
      cal_start = 1'b1;
      repeat (4) @(negedge ref_clk);
      cal_start = 1'b0;
   endtask
   // Gap so start is gone before done shows
   task automatic end_cal(input logic ok);
      @(negedge ref_clk);
      cal_ok = ok;
      cal_done = 1'b1;
      repeat (4) @(negedge ref_clk);
      cal_done = 1'b0;
      cal_ok = ~ok;
   endtask
endmodule

// >>> tb/input_clock_select_and_output_ctrl_test.sv
`timescale 1ns/1ps
module input_clock_select_and_output_ctrl_test
   import ics_pkg::*;
();
   logic ref_clk, reset, reg_wr, input_select_pin, pin_select_enable;
   logic input_one_bad, input_two_bad, cal_start, cal_done, cal_ok;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [3:0] active_bandwidth_code;
   logic select_input_two, pll_bypass, outputs_enable;
   logic cal_running, cal_complete;
   logic [7:0] rst_v [5] = '{8'h14, 8'he4, 8'h42, 8'h05, 8'h12};
   logic [7:0] wm_v [5] = '{8'h22, 8'h0f, 8'hf0, 8'hd0, 8'hc0};
   int err_count, num_checks;
   ics_clock_ctrl dut (
      .ref_clk(ref_clk),
      .reset(reset),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rdata(reg_rdata),
      .input_select_pin(input_select_pin),
      .pin_select_enable(pin_select_enable),
      .input_one_bad(input_one_bad),
      .input_two_bad(input_two_bad),
      .cal_start(cal_start),
      .cal_done(cal_done),
      .cal_ok(cal_ok),
      .select_input_two(select_input_two),
      .pll_bypass(pll_bypass),
      .outputs_enable(outputs_enable),
      .active_bandwidth_code(active_bandwidth_code),
      .cal_running(cal_running),
      .cal_complete(cal_complete)
   );
   ics_cal_model cal (.ref_clk, .cal_start, .cal_done, .cal_ok);
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic give_verdict();
      if (err_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      // Idle edge so the next strobe is not reassigned at once
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      tick(1);
      chk(reg_rdata, exp);
   endtask
   // Pin paths take two edges plus one for the select
   task automatic chk_sel(input logic exp);
      tick(5);
      chk(select_input_two, exp);
   endtask
   task automatic wait_run(input logic v);
      for (int i = 0; i < 20 && cal_running !== v; i++) begin
         tick(1);
      end
      if (cal_running !== v) begin
         err_count++;
         give_verdict();
      end
   endtask
   initial begin
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      input_select_pin = 1'b0;
      pin_select_enable = 1'b0;
      input_one_bad = 1'b0;
      input_two_bad = 1'b0;
      err_count = 0;
      num_checks = 0;
      tick(5);
      reset = 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd(i[7:0], rst_v[i]);
      end
      chk(outputs_enable, 1'b0);
      // Undefined bits of mapped registers are always written with their reset value
      for (int i = 0; i < 5; i++) begin
         wr(i[7:0], rst_v[i] | wm_v[i]);
         rd(i[7:0], rst_v[i] | wm_v[i]);
      end
      wr(8'h07, 8'hff);
      rd(8'h07, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr(i[7:0], rst_v[i]);
      end
      // Bypass only before first calibration, no CMOS outputs
      wr(8'h00, 8'h36);
      tick(3);
      chk(pll_bypass, 1'b1);
      chk(outputs_enable, 1'b1);
      wr(8'h00, 8'h14);
      tick(3);
      chk(pll_bypass, 1'b0);
      chk(outputs_enable, 1'b0);
      wr(8'h02, 8'h92);
      wr(8'h03, 8'h15);
      tick(3);
      chk(active_bandwidth_code, 4'h4);
      cal.begin_cal();
      wait_run(1'b1);
      chk(active_bandwidth_code, 4'h9);
      chk(outputs_enable, 1'b0);
      cal.end_cal(1'b1);
      wait_run(1'b0);
      tick(2);
      chk(cal_complete, 1'b1);
      chk(outputs_enable, 1'b1);
      wr(8'h03, 8'h05);
      cal.begin_cal();
      cal.end_cal(1'b0);
      wait_run(1'b0);
      tick(2);
      chk(outputs_enable, 1'b0);
      wr(8'h03, 8'h45);
      chk_sel(1'b1);
      wr(8'h03, 8'h85);
      chk_sel(1'b0);
      wr(8'h03, 8'h45);
      pin_select_enable = 1'b1;
      chk_sel(1'b0);
      input_select_pin = 1'b1;
      chk_sel(1'b1);
      pin_select_enable = 1'b0;
      wr(8'h01, 8'he1);
      wr(8'h04, 8'h92);
      chk_sel(1'b1);
      input_two_bad = 1'b1;
      chk_sel(1'b0);
      input_two_bad = 1'b0;
      chk_sel(1'b1);
      wr(8'h04, 8'h52);
      input_two_bad = 1'b1;
      chk_sel(1'b0);
      input_two_bad = 1'b0;
      chk_sel(1'b0);
      wr(8'h01, 8'he4);
      wr(8'h04, 8'h92);
      input_one_bad = 1'b1;
      chk_sel(1'b1);
      wr(8'h04, 8'hd2);
      input_one_bad = 1'b0;
      chk_sel(1'b1);
      give_verdict();
   end
endmodule
